// [common/bus_cfg_pkg.sv]
// Notes on behaviour
// RULE1: Divider select bit shows the strap; writes are taken but never stored.
// RULE2: Threshold select bit picks reset comparator levels 0.6/0.5V or 1.1/0.9V.
// RULE3: With reset enable clear, a low reset input leaves the output target alone.
// RULE4: With reset enable set, a low reset input ramps the target to boot voltage.
// RULE5: Setting reset enable while the input is already low starts the transition.
// RULE6: Select clear: fixed fault level 0.75/1.5/3.0/4.8V for mantissa 8/4/2/1.
// RULE7: Select set: fixed fault level 0.9/1.8/3.6/6.0V for mantissa 8/4/2/1.
// RULE8: Fixed fault control bit is inverted: zero enables detection, one disables.
// RULE9: A new bus address answers only after store-all and then a supply reset.
// RULE10: Common field 14:8 holds the primary address; restored value is answered.
// RULE11: Unique field 6:0 is secondary address; in a primary it equals common.
// RULE12: Address register bits 15 and 7 are read-only and read zero.
// RULE13: Word access, low byte first; writes to read-only bits are ignored.
package bus_cfg_pkg;
   localparam logic [7:0] CMD_STORE_ALL = 8'h15;
   localparam logic [7:0] CMD_SYS_CFG = 8'hD1;
   localparam logic [7:0] CMD_BUS_ADDR = 8'hD2;

   localparam int SYS_EXTERNAL_DIVIDER_SELECT_BIT = 4;
   localparam int SYS_RST_TH_BIT = 3;
   localparam int SYS_RST_EN_BIT = 2;
   localparam int SYS_OV_SEL_BIT = 1;
   localparam int SYS_OV_DIS_BIT = 0;
   // Bits 14:13 and 6:5 always zero, bit 4 never stored
   localparam logic [15:0] SYS_CFG_WMASK = 16'h9F8F;
   localparam int ADDR_COMMON_LSB = 8;
   localparam int ADDR_UNIQUE_LSB = 0;
   localparam int ADDR_W = 7;

   localparam logic [15:0] SYS_CFG_RESET = 16'h0000;
   localparam logic [6:0] ADDR_RESET = 7'h00;

   // Reset comparator levels in millivolts
   localparam logic [10:0] RST_TH_LO_VH_MV = 11'h258;
   localparam logic [10:0] RST_TH_LO_VL_MV = 11'h1F4;
   localparam logic [10:0] RST_TH_HI_VH_MV = 11'h44C;
   localparam logic [10:0] RST_TH_HI_VL_MV = 11'h384;

   // Fixed overvoltage levels in millivolts, index 0..3 = mantissa 8,4,2,1
   localparam logic [12:0] OV_LO_MV0 = 13'h02EE;
   localparam logic [12:0] OV_LO_MV1 = 13'h05DC;
   localparam logic [12:0] OV_LO_MV2 = 13'h0BB8;
   localparam logic [12:0] OV_LO_MV3 = 13'h12C0;
   localparam logic [12:0] OV_HI_MV0 = 13'h0384;
   localparam logic [12:0] OV_HI_MV1 = 13'h0708;
   localparam logic [12:0] OV_HI_MV2 = 13'h0E10;
   localparam logic [12:0] OV_HI_MV3 = 13'h1770;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_LOW = 2'b01,
      PH_HIGH = 2'b10,
      PH_DONE = 2'b11
   } byte_phase_t;
endpackage

// [design/bus_address_and_system_config.sv]
module bus_address_and_system_config
   import bus_cfg_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic cmd_strobe,
   input wire logic [7:0] cmd_code,
   input wire logic wr_byte_strobe,
   input wire logic [7:0] wr_byte,
   input wire logic rd_byte_strobe,
   input wire logic stop_strobe,
   input wire logic [15:0] nvm_sys_cfg,
   input wire logic [15:0] nvm_bus_address,
   input wire logic [3:0] loop_scale_mantissa,
   input wire logic external_divider_strap,
   input wire logic primary_strap,
   input wire logic output_reset_input,
   output logic [7:0] rd_byte_reg,
   output logic rd_valid_reg,
   output logic store_request_reg,
   output logic [15:0] store_sys_cfg_reg,
   output logic [15:0] store_bus_address_reg,
   output logic [6:0] response_address_reg,
   output logic reset_threshold_high_select_reg,
   output logic [10:0] reset_vh_mv_reg,
   output logic [10:0] reset_vl_mv_reg,
   output logic boot_transition_start_reg,
   output logic fixed_ov_detect_enable_reg,
   output logic [12:0] fixed_ov_threshold_mv_reg
);
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic restore_pending_reg;
   logic [15:0] sys_cfg_reg;
   logic [6:0] common_addr_reg;
   logic [6:0] unique_addr_reg;
   logic [7:0] cmd_reg;
   byte_phase_t wr_phase_reg;
   byte_phase_t rd_phase_reg;
   logic [7:0] low_byte_reg;
   logic reset_low_armed_reg;
   logic external_divider_select_sync;
   logic primary_sync;
   logic reset_pin_low;
   logic [15:0] sys_read;
   logic [15:0] addr_read;
   logic [15:0] word_read;
   logic [15:0] wr_word;
   logic word_done;

   function automatic logic [12:0] ov_level(input logic sel,
                                            input logic [3:0] mant);
      logic [12:0] lvl;
      lvl = sel ? OV_HI_MV3 : OV_LO_MV3;
      if (mant == 4'h8) begin
         lvl = sel ? OV_HI_MV0 : OV_LO_MV0; // RULE6 RULE7
      end else if (mant == 4'h4) begin
         lvl = sel ? OV_HI_MV1 : OV_LO_MV1; // RULE6 RULE7
      end else if (mant == 4'h2) begin
         lvl = sel ? OV_HI_MV2 : OV_LO_MV2; // RULE6 RULE7
      end
      return lvl;
   endfunction

   assign external_divider_select_sync = sync2_reg[0];
   assign primary_sync = sync2_reg[1];
   assign reset_pin_low = ~sync2_reg[2];

   // Unique field mirrors common in a primary part
   always_comb begin
      sys_read = sys_cfg_reg & SYS_CFG_WMASK;
      sys_read[SYS_EXTERNAL_DIVIDER_SELECT_BIT] = external_divider_select_sync; // RULE1
      addr_read = 16'h0000; // RULE12
      addr_read[ADDR_COMMON_LSB +: ADDR_W] = common_addr_reg; // RULE10
      addr_read[ADDR_UNIQUE_LSB +: ADDR_W] =
         primary_sync ? common_addr_reg : unique_addr_reg; // RULE11
      if (cmd_reg == CMD_SYS_CFG) begin
         word_read = sys_read;
      end else if (cmd_reg == CMD_BUS_ADDR) begin
         word_read = addr_read;
      end else begin
         word_read = 16'h0000;
      end
   end

   assign wr_word = {wr_byte, low_byte_reg}; // RULE13
   assign word_done = wr_byte_strobe && (wr_phase_reg == PH_HIGH);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 3'h7;
         sync2_reg <= 3'h7;
      end else if (clk_en) begin
         sync1_reg <= {output_reset_input, primary_strap,
                       external_divider_strap};
         sync2_reg <= sync1_reg;
      end
   end

   // Command phase tracking, low byte always first
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cmd_reg <= 8'h00;
         wr_phase_reg <= PH_IDLE;
         rd_phase_reg <= PH_IDLE;
         low_byte_reg <= 8'h00;
      end else if (clk_en) begin
         if (cmd_strobe) begin
            cmd_reg <= cmd_code;
            wr_phase_reg <= PH_LOW;
            rd_phase_reg <= PH_LOW;
         end else if (stop_strobe) begin
            wr_phase_reg <= PH_IDLE;
            rd_phase_reg <= PH_IDLE;
         end else begin
            if (wr_byte_strobe) begin
               if (wr_phase_reg == PH_LOW) begin
                  low_byte_reg <= wr_byte;
                  wr_phase_reg <= PH_HIGH;
               end else if (wr_phase_reg == PH_HIGH) begin
                  wr_phase_reg <= PH_DONE;
               end
            end
            if (rd_byte_strobe) begin
               if (rd_phase_reg == PH_LOW) begin
                  rd_phase_reg <= PH_HIGH;
               end else if (rd_phase_reg == PH_HIGH) begin
                  rd_phase_reg <= PH_DONE;
               end
            end
         end
      end
   end

   // Extra read bytes past the word return zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_byte_reg <= 8'h00;
         rd_valid_reg <= 1'b0;
      end else if (clk_en) begin
         rd_valid_reg <= rd_byte_strobe && !cmd_strobe && !stop_strobe;
         if (rd_byte_strobe && !cmd_strobe && !stop_strobe) begin
            if (rd_phase_reg == PH_LOW) begin
               rd_byte_reg <= word_read[7:0]; // RULE13
            end else if (rd_phase_reg == PH_HIGH) begin
               rd_byte_reg <= word_read[15:8]; // RULE13
            end else begin
               rd_byte_reg <= 8'h00;
            end
         end
      end
   end

   // Defaults load from nonvolatile copy on the first enabled cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         restore_pending_reg <= 1'b1;
         sys_cfg_reg <= SYS_CFG_RESET;
         common_addr_reg <= ADDR_RESET;
         unique_addr_reg <= ADDR_RESET;
         response_address_reg <= ADDR_RESET;
      end else if (clk_en) begin
         if (restore_pending_reg) begin
            restore_pending_reg <= 1'b0;
            sys_cfg_reg <= nvm_sys_cfg & SYS_CFG_WMASK;
            common_addr_reg <= nvm_bus_address[ADDR_COMMON_LSB +: ADDR_W];
            unique_addr_reg <= nvm_bus_address[ADDR_UNIQUE_LSB +: ADDR_W];
            // Answered address only changes here, never on a write
            response_address_reg <=
               nvm_bus_address[ADDR_COMMON_LSB +: ADDR_W]; // RULE9 RULE10
         end else if (word_done && !cmd_strobe && !stop_strobe) begin
            if (cmd_reg == CMD_SYS_CFG) begin
               sys_cfg_reg <= wr_word & SYS_CFG_WMASK; // RULE1 RULE13
            end else if (cmd_reg == CMD_BUS_ADDR) begin
               common_addr_reg <= wr_word[ADDR_COMMON_LSB +: ADDR_W];
               unique_addr_reg <= wr_word[ADDR_UNIQUE_LSB +: ADDR_W];
            end
         end
      end
   end

   // Store-all is a send-byte: the command with no data, then stop
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         store_request_reg <= 1'b0;
         store_sys_cfg_reg <= 16'h0000;
         store_bus_address_reg <= 16'h0000;
      end else if (clk_en) begin
         store_request_reg <= 1'b0;
         if (stop_strobe && !cmd_strobe && cmd_reg == CMD_STORE_ALL &&
             wr_phase_reg == PH_LOW) begin
            store_request_reg <= 1'b1; // RULE9
            store_sys_cfg_reg <= sys_read;
            store_bus_address_reg <= addr_read;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reset_threshold_high_select_reg <= 1'b0;
         reset_vh_mv_reg <= RST_TH_LO_VH_MV;
         reset_vl_mv_reg <= RST_TH_LO_VL_MV;
         fixed_ov_detect_enable_reg <= 1'b0;
         fixed_ov_threshold_mv_reg <= OV_LO_MV3;
      end else if (clk_en) begin
         reset_threshold_high_select_reg <= sys_cfg_reg[SYS_RST_TH_BIT];
         reset_vh_mv_reg <= sys_cfg_reg[SYS_RST_TH_BIT] ?
                            RST_TH_HI_VH_MV : RST_TH_LO_VH_MV; // RULE2
         reset_vl_mv_reg <= sys_cfg_reg[SYS_RST_TH_BIT] ?
                            RST_TH_HI_VL_MV : RST_TH_LO_VL_MV; // RULE2
         fixed_ov_detect_enable_reg <=
            !restore_pending_reg && !sys_cfg_reg[SYS_OV_DIS_BIT]; // RULE8
         fixed_ov_threshold_mv_reg <=
            ov_level(sys_cfg_reg[SYS_OV_SEL_BIT], loop_scale_mantissa);
      end
   end

   // Level-armed so enabling with the pin already low still fires once
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reset_low_armed_reg <= 1'b0;
         boot_transition_start_reg <= 1'b0;
      end else if (clk_en) begin
         reset_low_armed_reg <= sys_cfg_reg[SYS_RST_EN_BIT] &&
                                reset_pin_low && !restore_pending_reg;
         boot_transition_start_reg <= sys_cfg_reg[SYS_RST_EN_BIT] &&
            reset_pin_low && !restore_pending_reg &&
            !reset_low_armed_reg; // RULE3 RULE4 RULE5
      end
   end
endmodule

// [sim/bus_cfg_properties.sv]
module bus_cfg_properties (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic cmd_strobe,
   input wire logic [7:0] cmd_code,
   input wire logic rd_byte_strobe,
   input wire logic stop_strobe,
   input wire logic [15:0] nvm_bus_address,
   input wire logic rd_valid_reg,
   input wire logic store_request_reg,
   input wire logic [6:0] response_address_reg,
   input wire logic reset_threshold_high_select_reg,
   input wire logic [10:0] reset_vh_mv_reg,
   input wire logic [10:0] reset_vl_mv_reg,
   input wire logic boot_transition_start_reg
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence store_cmd_s;
      clk_en && cmd_strobe && cmd_code == 8'h15;
   endsequence
   sequence stop_s;
      clk_en && stop_strobe && !cmd_strobe;
   endsequence
   // Two cycles of select so a lag in the level outputs is tolerated
   thresh_high_a: assert property (reset_threshold_high_select_reg [*2] |->
      reset_vh_mv_reg == 11'h44C && reset_vl_mv_reg == 11'h384)
      else $error("high reset levels wrong");
   thresh_low_a: assert property (!reset_threshold_high_select_reg [*2] |->
      reset_vh_mv_reg == 11'h258 && reset_vl_mv_reg == 11'h1F4)
      else $error("low reset levels wrong");
   read_answer_a: assert property (clk_en && rd_byte_strobe && !cmd_strobe
      && !stop_strobe |=> rd_valid_reg) else $error("read not answered");
   read_cause_a: assert property (rd_valid_reg |-> $past(rd_byte_strobe))
      else $error("read answer without strobe");
   store_issue_a: assert property (store_cmd_s ##1 stop_s |=> store_request_reg)
      else $error("store request missing");
   store_cause_a: assert property (store_request_reg |-> $past(stop_strobe))
      else $error("store request without stop");
   boot_pulse_a: assert property (boot_transition_start_reg |=>
      !boot_transition_start_reg) else $error("boot start too long");
   address_hold_a: assert property ($changed(response_address_reg) |->
      !$past(rst_n, 2)) else $error("address changed outside restore");
   address_restore_a: assert property (rst_n && !$past(rst_n) |=>
      response_address_reg == $past(nvm_bus_address[14:8]))
      else $error("restored address wrong");
endmodule

bind bus_address_and_system_config bus_cfg_properties CHK (.clock, .rst_n,
   .clk_en, .cmd_strobe, .cmd_code, .rd_byte_strobe, .stop_strobe,
   .nvm_bus_address, .rd_valid_reg, .store_request_reg, .response_address_reg,
   .reset_threshold_high_select_reg, .reset_vh_mv_reg, .reset_vl_mv_reg,
   .boot_transition_start_reg);

// [sim/host_model.sv]
module host_model (
   input wire logic clock,
   input wire logic [7:0] rd_byte_reg,
   input wire logic rd_valid_reg,
   output logic cmd_strobe,
   output logic [7:0] cmd_code,
   output logic wr_byte_strobe,
   output logic [7:0] wr_byte,
   output logic rd_byte_strobe,
   output logic stop_strobe
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {cmd_strobe, wr_byte_strobe, rd_byte_strobe, stop_strobe} = 4'h0;
      cmd_code = 8'h00;
      wr_byte = 8'h00;
   end
   // A byte not answered comes back unknown so the caller's compare fails
   task automatic xfer(input logic [7:0] c, input logic wr,
      input logic [15:0] d, input int n, output logic [15:0] q);
      q = 16'h0000;
      @(negedge clock);
      cmd_strobe = 1'b1;
      cmd_code = c;
      for (int i = 0; i <= n; i++) begin
         @(negedge clock);
         if (i > 0 && !wr)
            q[8*(i-1) +: 8] = rd_valid_reg ? rd_byte_reg : 8'hXX;
         cmd_strobe = 1'b0;
         wr_byte_strobe = wr && i < n;
         rd_byte_strobe = !wr && i < n;
         wr_byte = i[0] ? d[15:8] : d[7:0];
         stop_strobe = i == n;
      end
      @(negedge clock);
      stop_strobe = 1'b0;
   endtask
endmodule

// [sim/bus_address_and_system_config_bench.sv]
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
   $display("mismatch at %0t: got %h want %h", $time, a, e); end end
module bus_address_and_system_config_bench;
   import bus_cfg_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic [15:0] nvm_sys_cfg, nvm_bus_address, q, w;
   logic [3:0] loop_scale_mantissa;
   logic external_divider_strap, primary_strap, output_reset_input;
   wire logic cmd_strobe, wr_byte_strobe, rd_byte_strobe, stop_strobe;
   wire logic [7:0] cmd_code, wr_byte, rd_byte_reg;
   wire logic rd_valid_reg, store_request_reg, reset_threshold_high_select_reg;
   wire logic boot_transition_start_reg, fixed_ov_detect_enable_reg;
   wire logic [15:0] store_sys_cfg_reg, store_bus_address_reg;
   wire logic [6:0] response_address_reg;
   wire logic [10:0] reset_vh_mv_reg, reset_vl_mv_reg;
   wire logic [12:0] fixed_ov_threshold_mv_reg;
   int err_total = 0;
   int checks = 0;
   int pulses = 0;
   logic [31:0] seed = 32'h00000D4A;
   always #25 clock = ~clock;
   always @(posedge clock) if (boot_transition_start_reg === 1'b1) pulses++;
   bus_address_and_system_config DUT (.clock, .rst_n, .clk_en, .cmd_strobe,
      .cmd_code, .wr_byte_strobe, .wr_byte, .rd_byte_strobe, .stop_strobe,
      .nvm_sys_cfg, .nvm_bus_address, .loop_scale_mantissa,
      .external_divider_strap, .primary_strap, .output_reset_input,
      .rd_byte_reg, .rd_valid_reg, .store_request_reg, .store_sys_cfg_reg,
      .store_bus_address_reg, .response_address_reg,
      .reset_threshold_high_select_reg, .reset_vh_mv_reg, .reset_vl_mv_reg,
      .boot_transition_start_reg, .fixed_ov_detect_enable_reg,
      .fixed_ov_threshold_mv_reg);
   host_model HOST (.clock, .rd_byte_reg, .rd_valid_reg, .cmd_strobe,
      .cmd_code, .wr_byte_strobe, .wr_byte, .rd_byte_strobe, .stop_strobe);
   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction
   function automatic logic [15:0] exp_sys(input logic [15:0] v);
      return {v[15], 2'b00, v[12:7], 2'b00, external_divider_strap, v[3:0]};
   endfunction
   function automatic logic [15:0] exp_adr(input logic [15:0] v);
      return {1'b0, v[14:8], 1'b0, primary_strap ? v[14:8] : v[6:0]};
   endfunction
   // Fixed fault level in mV; any other mantissa is not a documented case
   function automatic logic [12:0] ov_mv(input logic s, input logic [3:0] m);
      case (m)
         4'h8: return s ? 13'h0384 : 13'h02EE;
         4'h4: return s ? 13'h0708 : 13'h05DC;
         4'h2: return s ? 13'h0E10 : 13'h0BB8;
         default: return s ? 13'h1770 : 13'h12C0;
      endcase
   endfunction
   task automatic rd(input logic [7:0] c);
      HOST.xfer(c, 1'b0, 16'h0000, 2, q);
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      HOST.xfer(c, 1'b1, d, 2, q);
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (16) @(negedge clock);
      rst_n = 1'b1;
      repeat (6) @(negedge clock);
   endtask
   task automatic wait_pin(input logic v);
      output_reset_input = v;
      repeat (10) @(negedge clock);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      report_and_stop();
   end
   initial begin
      nvm_sys_cfg = rnd() & 16'hFFFB;
      nvm_bus_address = rnd();
      loop_scale_mantissa = 4'h8;
      external_divider_strap = 1'b1;
      primary_strap = 1'b0;
      output_reset_input = 1'b1;
      do_reset();
      `CHK(response_address_reg, nvm_bus_address[14:8])
      rd(CMD_BUS_ADDR);
      `CHK(q, exp_adr(nvm_bus_address))
      rd(CMD_SYS_CFG);
      `CHK(q, exp_sys(nvm_sys_cfg))
      for (int i = 0; i < 8; i++) begin
         w = rnd();
         loop_scale_mantissa = 4'h1 << i[1:0];
         external_divider_strap = i[0];
         primary_strap = i[1];
         wr(CMD_SYS_CFG, w);
         rd(CMD_SYS_CFG);
         `CHK(q, exp_sys(w))
         `CHK(reset_vh_mv_reg, w[3] ? 11'h44C : 11'h258)
         `CHK(reset_vl_mv_reg, w[3] ? 11'h384 : 11'h1F4)
         `CHK(reset_threshold_high_select_reg, w[3])
         `CHK(fixed_ov_detect_enable_reg, !w[0])
         `CHK(fixed_ov_threshold_mv_reg, ov_mv(w[1], loop_scale_mantissa))
         wr(CMD_BUS_ADDR, w);
         rd(CMD_BUS_ADDR);
         `CHK(q, exp_adr(w))
         `CHK(response_address_reg, nvm_bus_address[14:8])
      end
      HOST.xfer(CMD_STORE_ALL, 1'b0, 16'h0000, 0, q);
      `CHK(store_request_reg, 1'b1)
      `CHK(store_sys_cfg_reg, exp_sys(w))
      `CHK(store_bus_address_reg, exp_adr(w))
      @(negedge clock);
      `CHK(store_request_reg, 1'b0)
      nvm_bus_address = w;
      do_reset();
      `CHK(response_address_reg, w[14:8])
      wr(CMD_SYS_CFG, 16'h0000);
      pulses = 0;
      wait_pin(1'b0);
      `CHK(pulses, 0)
      wr(CMD_SYS_CFG, 16'h0004);
      repeat (10) @(negedge clock);
      `CHK(pulses, 1)
      wait_pin(1'b1);
      wait_pin(1'b0);
      `CHK(pulses, 2)
      // A write made while the enable is low must leave no trace
      clk_en = 1'b0;
      wr(CMD_SYS_CFG, 16'h0008);
      clk_en = 1'b1;
      rd(CMD_SYS_CFG);
      `CHK(q, exp_sys(16'h0004))
      `CHK(reset_vh_mv_reg, RST_TH_LO_VH_MV)
      report_and_stop();
   end
endmodule
